// *** rtl/fsr_defines.svh ***
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH
// register byte offsets on the bus
`define FSR_OFS_PRIMARY    12'h000
`define FSR_OFS_SECONDARY  12'h004
`define FSR_OFS_CONFIG     12'h008
// primary status bit positions
`define FSR_P_BUCK_UVF     7
`define FSR_P_BUCK_UVW     6
`define FSR_P_BUCK_OCW     5
`define FSR_P_SUP_OVF      4
`define FSR_P_DRV_OVF      3
`define FSR_P_SUP_UVF      2
`define FSR_P_OT_F         1
`define FSR_P_OT_W         0
// secondary status bit positions
`define FSR_S_FIVE_UV      5
`define FSR_S_CFG_LOST     4
`define FSR_S_EXT_OC       3
`define FSR_S_GATE_UV      2
// config field positions
`define FSR_C_SC_DETECT    2
`define FSR_C_OC_SEL_HI    1
`define FSR_C_OC_SEL_LO    0
// reset values
`define FSR_RST_PRIMARY    8'h00
`define FSR_RST_SECONDARY  8'h10
`define FSR_RST_CONFIG     8'h00
`define FSR_RST_CFG_LOST   1'b1
// overcurrent thresholds in millivolts per select code
`define FSR_OC_MV_0        10'h0FA
`define FSR_OC_MV_1        10'h1F4
`define FSR_OC_MV_2        10'h2EE
`define FSR_OC_MV_3        10'h3E8
`define FSR_PSLVERR_UNMAP  1'b1
`endif

// *** rtl/fsr_pkg.sv ***
package fsr_pkg;
  typedef logic [7:0] fsr_byte_t;
  typedef logic [9:0] fsr_mv_t;
endpackage

// *** rtl/fsr_status_regs.sv ***
`timescale 1ns/1ps
`include "fsr_defines.svh"
module fsr_status_regs #(
  parameter bit HAS_DRV_OV_DETECT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        buck_below_80,
  input  wire logic        buck_below_90,
  input  wire logic        buck_in_over_2a,
  input  wire logic        supply_over_32v,
  input  wire logic        driver_supply_over_20v,
  input  wire logic        supply_below_5v5,
  input  wire logic        temp_over_160c,
  input  wire logic        temp_over_115c,
  input  wire logic        five_volt_below_4v,
  input  wire logic [9:0]  ext_fet_vds_mv,
  input  wire logic [2:0]  gate_out_below_8v,
  input  wire logic        config_message_rx,
  output logic      [1:0]  overcurrent_threshold_select,
  output logic             short_circuit_detect_setting,
  output logic             ext_oc_valid
);
  // synchroniser lanes: bit 0 carries the config strobe, bits 1 to 10 the monitors
  logic [10:0]        raw_lvl;
  logic [10:0]        sync1_ff;
  logic [10:0]        sync2_ff;
  logic [10:0]        sync3_ff;
  logic [10:0]        live_ff;

  // accepted level of each lane, named by what it reports
  wire                lvl_cfg_rx;
  wire                lvl_buck_uvf;
  wire                lvl_buck_uvw;
  wire                lvl_buck_ocw;
  wire                lvl_sup_ovf;
  wire                lvl_drv_ovf;
  wire                lvl_sup_uvf;
  wire                lvl_ot_f;
  wire                lvl_ot_w;
  wire                lvl_five_uv;
  wire                lvl_gate_uv;

  // config message edge detect and the flag it clears
  logic               cfg_rx_seen_ff;
  wire                cfg_rx_pulse;
  logic               cfg_lost_ff;

  // external transistor overcurrent compare
  fsr_pkg::fsr_mv_t   oc_limit_mv;
  wire                nxt_ext_oc;
  logic               ext_oc_ff;

  // status bytes and their next values
  fsr_pkg::fsr_byte_t primary_ff;
  fsr_pkg::fsr_byte_t secondary_ff;
  fsr_pkg::fsr_byte_t nxt_primary;
  fsr_pkg::fsr_byte_t nxt_secondary;

  // config byte and its write path
  fsr_pkg::fsr_byte_t cfg_ff;
  fsr_pkg::fsr_byte_t nxt_cfg;
  wire                cfg_wr_en;

  // bus phases and decode
  wire                setup_phase;
  wire                access;
  wire                hit_primary;
  wire                hit_secondary;
  wire                hit_config;
  wire                unmapped;
  wire  [31:0]        word_primary;
  wire  [31:0]        word_secondary;
  wire  [31:0]        word_config;
  wire  [31:0]        rd_mux;
  wire  [31:0]        nxt_prdata;
  wire                nxt_pslverr;

  // bus answer registers
  logic [31:0]        prdata_ff;
  logic               pslverr_ff;

  // monitor levels and the config strobe gathered into lanes;
  // a monitor change shows in its status bit five clocks later,
  // and a level shorter than about two clocks may never be seen,
  // which is acceptable for slow analog comparators
  assign raw_lvl[0]  = config_message_rx;
  assign raw_lvl[1]  = buck_below_80;
  assign raw_lvl[2]  = buck_below_90;
  assign raw_lvl[3]  = buck_in_over_2a;
  assign raw_lvl[4]  = supply_over_32v;
  assign raw_lvl[5]  = driver_supply_over_20v;
  assign raw_lvl[6]  = supply_below_5v5;
  assign raw_lvl[7]  = temp_over_160c;
  assign raw_lvl[8]  = temp_over_115c;
  assign raw_lvl[9]  = five_volt_below_4v;
  assign raw_lvl[10] = |gate_out_below_8v; // any high-side output low

  // three sync flops and an accepted-level flop per lane; a change is taken once stages two and three
  // agree, so one unsettled sample never reaches the status bytes;
  // only stage two reads stage one
  genvar g;
  generate
    for (g = 0; g < 11; g++) begin : g_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
          sync3_ff[g] <= 1'b0;
          live_ff[g]  <= 1'b0;
        end else begin
          sync1_ff[g] <= raw_lvl[g];
          sync2_ff[g] <= sync1_ff[g];
          sync3_ff[g] <= sync2_ff[g];
          if (sync2_ff[g] == sync3_ff[g]) begin
            live_ff[g] <= sync3_ff[g];
          end
        end
      end
    end
  endgenerate

  // named views of the accepted levels
  assign lvl_cfg_rx   = live_ff[0];
  assign lvl_buck_uvf = live_ff[1];
  assign lvl_buck_uvw = live_ff[2];
  assign lvl_buck_ocw = live_ff[3];
  assign lvl_sup_ovf  = live_ff[4];
  assign lvl_drv_ovf  = live_ff[5];
  assign lvl_sup_uvf  = live_ff[6];
  assign lvl_ot_f     = live_ff[7];
  assign lvl_ot_w     = live_ff[8];
  assign lvl_five_uv  = live_ff[9];
  assign lvl_gate_uv  = live_ff[10];

  // previous strobe level; idle is low, so no false edge after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rx_seen_ff <= 1'b0;
    end else begin
      cfg_rx_seen_ff <= lvl_cfg_rx;
    end
  end

  // one-cycle pulse on the rising edge of the accepted strobe
  assign cfg_rx_pulse = lvl_cfg_rx & ~cfg_rx_seen_ff;

  // config lost: set by any reset, cleared only by a config message;
  // the set side is the reset itself, so no set and clear race exists
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_lost_ff <= `FSR_RST_CFG_LOST;
    end else if (cfg_rx_pulse) begin
      cfg_lost_ff <= 1'b0;
    end
  end

  // threshold per select code
  always_comb begin
    case (cfg_ff[`FSR_C_OC_SEL_HI:`FSR_C_OC_SEL_LO])
      2'h0:    oc_limit_mv = `FSR_OC_MV_0;
      2'h1:    oc_limit_mv = `FSR_OC_MV_1;
      2'h2:    oc_limit_mv = `FSR_OC_MV_2;
      default: oc_limit_mv = `FSR_OC_MV_3;
    endcase
  end

  // strictly above the limit counts; equal reads as below;
  // the measurement is already on this clock, so it skips the lanes
  assign nxt_ext_oc = ext_fet_vds_mv > oc_limit_mv;

  // compare registered once before it enters the status byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_oc_ff <= 1'b0;
    end else begin
      ext_oc_ff <= nxt_ext_oc;
    end
  end

  // primary byte follows the accepted levels;
  // bit three is forced low on the variant without the driver detector
  always_comb begin
    nxt_primary                  = 8'h00;
    nxt_primary[`FSR_P_BUCK_UVF] = lvl_buck_uvf;
    nxt_primary[`FSR_P_BUCK_UVW] = lvl_buck_uvw;
    nxt_primary[`FSR_P_BUCK_OCW] = lvl_buck_ocw;
    nxt_primary[`FSR_P_SUP_OVF]  = lvl_sup_ovf;
    nxt_primary[`FSR_P_DRV_OVF]  = lvl_drv_ovf & HAS_DRV_OV_DETECT;
    nxt_primary[`FSR_P_SUP_UVF]  = lvl_sup_uvf;
    nxt_primary[`FSR_P_OT_F]     = lvl_ot_f;
    nxt_primary[`FSR_P_OT_W]     = lvl_ot_w;
  end

  // secondary byte; unused positions stay zero,
  // the config lost bit comes from its own flag
  always_comb begin
    nxt_secondary                  = 8'h00;
    nxt_secondary[`FSR_S_FIVE_UV]  = lvl_five_uv;
    nxt_secondary[`FSR_S_CFG_LOST] = cfg_lost_ff;
    nxt_secondary[`FSR_S_EXT_OC]   = ext_oc_ff;
    nxt_secondary[`FSR_S_GATE_UV]  = lvl_gate_uv;
  end

  // status registers; reads never disturb them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      primary_ff   <= `FSR_RST_PRIMARY;
      secondary_ff <= `FSR_RST_SECONDARY;
    end else begin
      primary_ff   <= nxt_primary;
      secondary_ff <= nxt_secondary;
    end
  end

  // bus phases and address decode;
  // full compare, so aliases of a register read as unmapped
  assign setup_phase   = psel & ~penable;
  assign access        = psel & penable;
  assign hit_primary   = paddr == `FSR_OFS_PRIMARY;
  assign hit_secondary = paddr == `FSR_OFS_SECONDARY;
  assign hit_config    = paddr == `FSR_OFS_CONFIG;
  assign unmapped      = ~(hit_primary | hit_secondary | hit_config);

  // register words; upper bytes read zero
  assign word_primary   = {24'h000000, primary_ff};
  assign word_secondary = {24'h000000, secondary_ff};
  assign word_config    = {24'h000000, cfg_ff};

  // read selection; unmapped offsets read zero
  assign rd_mux = hit_primary   ? word_primary :
                  hit_secondary ? word_secondary :
                  hit_config    ? word_config : 32'h00000000;

  // only the config offset takes writes; status writes are dropped,
  // and byte lane zero alone gates the config byte
  assign cfg_wr_en = access & pready & pwrite & hit_config & pstrb[0]; // status offsets not writable
  assign nxt_cfg   = {5'h00, pwdata[`FSR_C_SC_DETECT:`FSR_C_OC_SEL_LO]};

  // config register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= `FSR_RST_CONFIG;
    end else if (cfg_wr_en) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // answer chosen in the setup cycle so it stands through the access phase;
  // writes capture zero so a stale word never shows
  assign nxt_prdata  = pwrite ? 32'h00000000 : rd_mux;
  assign nxt_pslverr = unmapped ? `FSR_PSLVERR_UNMAP : 1'b0;

  // read data and error registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup_phase) begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // zero wait states: every transfer answers in its first access cycle
  assign pready = 1'b1;

  // data from flops, error only shown in the access phase
  assign prdata  = prdata_ff;
  assign pslverr = access & pslverr_ff;

  // config fields seen by the monitors and the host
  assign overcurrent_threshold_select = cfg_ff[`FSR_C_OC_SEL_HI:`FSR_C_OC_SEL_LO];
  assign short_circuit_detect_setting = cfg_ff[`FSR_C_SC_DETECT];

  // host must ignore the ext overcurrent flag while this is low
  assign ext_oc_valid = cfg_ff[`FSR_C_SC_DETECT];
endmodule

// *** verification/fsr_status_regs_assertions.sv ***
`timescale 1ns/1ps
`include "fsr_defines.svh"
module fsr_status_regs_assertions (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_oc_valid,
  input wire logic        short_circuit_detect_setting,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  pstrb,
  input wire logic [1:0]  overcurrent_threshold_select
);
  // access phase, address decode and config view
  wire       acc = psel && penable;
  wire       rd  = acc && !pwrite;
  wire       hit = paddr == `FSR_OFS_PRIMARY || paddr == `FSR_OFS_SECONDARY || paddr == `FSR_OFS_CONFIG;
  wire       cwr = acc && pwrite && paddr == `FSR_OFS_CONFIG && pstrb[0];
  wire [2:0] cfg = {short_circuit_detect_setting, overcurrent_threshold_select};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_UNMAPPED_ERR: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (acc && hit |-> pready && !pslverr)
    else $error("mapped access refused");
  AST_SEC_UNUSED: assert property (rd && paddr == `FSR_OFS_SECONDARY |-> {prdata[7:6], prdata[1:0]} == 4'h0)
    else $error("unused secondary bits set");
  AST_UPPER_ZERO: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_VALID_TRACK: assert property (cwr |=> ext_oc_valid == $past(pwdata[2]))
    else $error("valid flag does not follow detect bit");
  AST_CFG_WRITE: assert property (cwr |=> cfg == $past(pwdata[2:0]))
    else $error("config write not taken");
  AST_CFG_HOLD: assert property (!cwr |=> $stable(cfg))
    else $error("config changed without write");
  AST_RESET_IDLE: assert property ($rose(resetn) |-> prdata == 32'h0 && !pslverr && cfg == 3'h0)
    else $error("outputs not idle after reset");
  // main scenarios
  COV_SEC_READ: cover property (rd && paddr == `FSR_OFS_SECONDARY);
  COV_CFG_WRITE: cover property (cwr);
  COV_UNMAPPED: cover property (acc && !hit);
endmodule
bind fsr_status_regs fsr_status_regs_assertions i_chk (.*);

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] p; logic f; logic [2:0] g; logic [9:0] v; logic [1:0] c; logic [7:0] s;} fsr_row_t;
  logic        clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic        five_volt_below_4v = 1'h0, config_message_rx = 1'h0, pready, pslverr, ext_oc_valid;
  logic        short_circuit_detect_setting;
  logic [1:0]  overcurrent_threshold_select;
  logic [2:0]  gate_out_below_8v = 3'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  pi = 8'h00;
  logic [9:0]  ext_fet_vds_mv = 10'h000;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] prdata_b, rd_b;
  int          fails = 0, tests_run = 0, cyc = 0;
  wire buck_below_80 = pi[7], buck_below_90 = pi[6], buck_in_over_2a = pi[5], supply_over_32v = pi[4];
  wire driver_supply_over_20v = pi[3], supply_below_5v5 = pi[2], temp_over_160c = pi[1], temp_over_115c = pi[0];
  // rows: primary levels, 5v low, gate low, vds mv, threshold code, expected secondary
  fsr_row_t rows [9] = '{'{8'hFF, 1'h1, 3'h7, 10'h3FF, 2'h0, 8'h3C}, '{8'h80, 1'h0, 3'h0, 10'h0FB, 2'h0, 8'h18},
    '{8'h40, 1'h1, 3'h1, 10'h1F4, 2'h1, 8'h34}, '{8'h20, 1'h0, 3'h2, 10'h2EF, 2'h2, 8'h1C},
    '{8'h10, 1'h0, 3'h4, 10'h3E8, 2'h3, 8'h14}, '{8'h08, 1'h0, 3'h0, 10'h3E9, 2'h3, 8'h18},
    '{8'h04, 1'h0, 3'h0, 10'h1F5, 2'h0, 8'h18}, '{8'h02, 1'h0, 3'h0, 10'h0FA, 2'h0, 8'h10},
    '{8'h01, 1'h0, 3'h0, 10'h000, 2'h0, 8'h10}};
  always #5 clk = ~clk;
  fsr_status_regs i_dut (.*);
  // variant without the driver supply detector; shares the bus, own read data
  fsr_status_regs #(.HAS_DRV_OV_DETECT(1'b0)) i_dut_no_drv (.*, .prdata(prdata_b), .pready(), .pslverr(),
    .overcurrent_threshold_select(), .short_circuit_detect_setting(), .ext_oc_valid());
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata; err = pslverr;
    rd_b = prdata_b;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    chk("prdata in reset", 32'h0, prdata);
    rdc("primary", 12'h000, 32'h00);
    rdc("secondary", 12'h004, 32'h10);
    rdc("config", 12'h008, 32'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      pi <= rows[i].p; five_volt_below_4v <= rows[i].f; gate_out_below_8v <= rows[i].g; ext_fet_vds_mv <= rows[i].v;
      apb(1'h1, 12'h008, {29'h0, 1'h1, rows[i].c});
      repeat (8) @(posedge clk);
      rdc("primary", 12'h000, {24'h0, rows[i].p});
      chk("primary no detector", {24'h0, rows[i].p & 8'hF7}, rd_b);
      rdc("secondary", 12'h004, {24'h0, rows[i].s});
      chk("ext valid", 32'h1, {31'h0, ext_oc_valid});
      chk("threshold select", {30'h0, rows[i].c}, {30'h0, overcurrent_threshold_select});
      chk("detect setting", 32'h1, {31'h0, short_circuit_detect_setting});
    end
    $display("test flag table done");
    config_message_rx <= 1'h1;
    repeat (8) @(posedge clk);
    config_message_rx <= 1'h0;
    rdc("config lost", 12'h004, 32'h00);
    apb(1'h1, 12'h000, 32'hFF);
    chk("status write error", 32'h0, {31'h0, err});
    rdc("primary kept", 12'h000, 32'h01);
    rdc("primary reread", 12'h000, 32'h01);
    rdc("config back", 12'h008, 32'h04);
    rdc("unmapped data", 12'h00C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test access done");
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    rdc("secondary", 12'h004, 32'h10);
    chk("ext valid after reset", 32'h0, {31'h0, ext_oc_valid});
    chk("threshold after reset", 32'h0, {30'h0, overcurrent_threshold_select});
    $display("test second reset done");
    give_verdict;
  end
endmodule
